// [include/lrc_pkg.sv]
// constants, field layout and state type for the linear regulator
// control bank; shared by the bank top and its per-regulator slice
`default_nettype none
package lrc_pkg;

    localparam int LRC_NUM = 4;
    localparam int LRC_ADDR_W = 10;
    localparam int LRC_DATA_W = 8;
    localparam int LRC_NUM_INPUTS = 3;

    // register addresses
    localparam logic [9:0] LRC_ADDR_CTRL1 = 10'h026;
    localparam logic [9:0] LRC_ADDR_CTRL2 = 10'h027;
    localparam logic [9:0] LRC_ADDR_CTRL3 = 10'h028;
    localparam logic [9:0] LRC_ADDR_CTRL4 = 10'h029;
    localparam logic [9:0] LRC_ADDR_VSEL = 10'h032;

    // control register fields
    localparam int LRC_BIT_SEQ = 7;
    localparam int LRC_VSEL_HI = 6;
    localparam int LRC_VSEL_LO = 5;
    localparam int LRC_BIT_SPARE = 4;
    localparam int LRC_BIT_PDOFF = 3;
    localparam int LRC_ESEL_HI = 2;
    localparam int LRC_ESEL_LO = 1;
    localparam int LRC_BIT_ON = 0;

    // voltage selection register: regulator n at bit LRC_VSEL_BASE+n
    localparam int LRC_VSEL_BASE = 4;

    // input selection codes
    localparam logic [1:0] LRC_SEL_SEQ = 2'h0;
    localparam logic [1:0] LRC_SEL_ONE = 2'h1;
    localparam logic [1:0] LRC_SEL_TWO = 2'h2;
    localparam logic [1:0] LRC_SEL_THREE = 2'h3;

    // reset values
    localparam logic [7:0] LRC_CTRL_RESET = 8'h00;
    localparam logic LRC_VOLT_RESET = 1'b0;
    localparam logic [7:0] LRC_RDATA_NONE = 8'h00;

    // spacing between two switching steps of the priority order
    localparam int LRC_CLOCK_NS = 50;
    localparam int LRC_STEP_NS = 1000;
    localparam int LRC_STEP_CYCLES =
        (LRC_STEP_NS + LRC_CLOCK_NS - 1) / LRC_CLOCK_NS;

    typedef enum logic [1:0] {
        LRC_ST_IDLE = 2'b00,
        LRC_ST_WAIT = 2'b01,
        LRC_ST_APPLY = 2'b11
    } lrc_state_e;

endpackage
`default_nettype wire

// [src/lrc_channel.sv]
// one regulator slice: control register, voltage selection bit and
// the input edge handling that modifies them
// assumes edge pulses of the three general inputs come from the top
`timescale 1ns/1ps
`default_nettype none
module lrc_channel (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ctrl_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_volt_wr,
    input wire logic i_volt_wdata,
    input wire logic i_standby,
    input wire logic [2:0] i_rise,
    input wire logic [2:0] i_fall,
    output logic [7:0] o_ctrl,
    output logic o_volt_second,
    output logic o_request
);
    import lrc_pkg::*;

    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic volt;
    logic next_volt;
    logic [1:0] vsel;
    logic [1:0] esel;
    logic v_rise;
    logic v_fall;
    logic e_rise;
    logic e_fall;

    assign vsel = ctrl[LRC_VSEL_HI:LRC_VSEL_LO];
    assign esel = ctrl[LRC_ESEL_HI:LRC_ESEL_LO];

    // RULE3: voltage input decode
    // RULE5: enable input decode
    always_comb begin
        v_rise = 1'b0;
        v_fall = 1'b0;
        e_rise = 1'b0;
        e_fall = 1'b0;
        case (vsel)
            LRC_SEL_ONE: begin
                v_rise = i_rise[0];
                v_fall = i_fall[0];
            end
            LRC_SEL_TWO: begin
                v_rise = i_rise[1];
                v_fall = i_fall[1];
            end
            LRC_SEL_THREE: begin
                v_rise = i_rise[2];
                v_fall = i_fall[2];
            end
            default: begin
                v_rise = 1'b0;
                v_fall = 1'b0;
            end
        endcase
        case (esel)
            LRC_SEL_ONE: begin
                e_rise = i_rise[0];
                e_fall = i_fall[0];
            end
            LRC_SEL_TWO: begin
                e_rise = i_rise[1];
                e_fall = i_fall[1];
            end
            LRC_SEL_THREE: begin
                e_rise = i_rise[2];
                e_fall = i_fall[2];
            end
            default: begin
                e_rise = 1'b0;
                e_fall = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_ctrl = ctrl;
        next_volt = volt;
        // RULE9: spare bit stored as written
        if (i_ctrl_wr) begin
            next_ctrl = i_wdata;
        end
        // RULE8: voltage selection bit
        if (i_volt_wr) begin
            next_volt = i_volt_wdata;
        end
        // RULE2: rising input picks setting a
        if (v_rise) begin
            next_volt = 1'b0;
        end else if (v_fall) begin
            next_volt = 1'b1;
        end
        // RULE4: input edges switch enable
        if (e_rise) begin
            next_ctrl[LRC_BIT_ON] = 1'b1;
        end else if (e_fall) begin
            next_ctrl[LRC_BIT_ON] = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl <= LRC_CTRL_RESET;
            volt <= LRC_VOLT_RESET;
        end else begin
            ctrl <= next_ctrl;
            volt <= next_volt;
        end
    end

    assign o_ctrl = ctrl;
    assign o_volt_second = volt;
    // RULE1: sequenced supply stays on in standby
    // RULE7: enable bit requests on or off
    assign o_request = ctrl[LRC_BIT_ON] &
        (~i_standby | ctrl[LRC_BIT_SEQ]);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_rise_sets_on: assert property ( // RULE4
        (esel == LRC_SEL_TWO && i_rise[1]) |=> ctrl[LRC_BIT_ON])
        else $error("enable rise did not set on bit");
    a_fall_clears_on: assert property ( // RULE4
        (esel == LRC_SEL_THREE && i_fall[2]) |=> !ctrl[LRC_BIT_ON])
        else $error("enable fall did not clear on bit");
    a_vrise_picks_a: assert property ( // RULE2
        (vsel == LRC_SEL_ONE && i_rise[0]) |=> !volt)
        else $error("voltage rise did not pick setting a");
    a_seq_ignores_pins: assert property ( // RULE5
        (esel == LRC_SEL_SEQ && !i_ctrl_wr) |=> $stable(ctrl[LRC_BIT_ON]))
        else $error("on bit moved under sequencer control");
    a_spare_readback: assert property ( // RULE9
        i_ctrl_wr |=> ctrl[LRC_BIT_SPARE] == $past(i_wdata[LRC_BIT_SPARE]))
        else $error("spare bit not stored");
    a_standby_drop: assert property ( // RULE1
        (i_standby && !ctrl[LRC_BIT_SEQ]) |-> !o_request)
        else $error("unsequenced supply requested in standby");
    c_pin_enable: cover property (
        (esel != LRC_SEL_SEQ) && e_rise ##1 ctrl[LRC_BIT_ON]);
endmodule
`default_nettype wire

// [src/lrc_regs.sv]
// control register bank for four linear regulators with the step
// sequencer that applies on/off changes one at a time
// assumes register port and general inputs are synchronous to i_clock
//
// Notes on behaviour
// RULE1: bit 7 set keeps the regulator on in the standby state.
// RULE2: selected voltage input rising edge picks voltage setting a.
// RULE3: bits 6:5 pick voltage input: sequencer, input one, two, three.
// RULE4: selected enable input rising turns on, falling turns off.
// RULE5: bits 2:1 pick enable input: sequencer, input one, two, three.
// RULE6: bit 3 clear keeps pull-down on while off; set removes it.
// RULE7: bit 0 requests on or off; switching follows step priority.
// RULE8: per-regulator selection bit: 0 setting a, 1 setting b.
// RULE9: bit 4 reads back as written and steers nothing.
`timescale 1ns/1ps
`default_nettype none
module lrc_regs #(
    parameter int STEP_CYCLES = lrc_pkg::LRC_STEP_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [lrc_pkg::LRC_ADDR_W-1:0] i_addr,
    input wire logic [lrc_pkg::LRC_DATA_W-1:0] i_wdata,
    input wire logic i_general_input_one,
    input wire logic i_general_input_two,
    input wire logic i_general_input_three,
    input wire logic i_low_power_standby_state,
    output logic [lrc_pkg::LRC_DATA_W-1:0] o_rdata,
    output logic o_rd_valid,
    output logic [lrc_pkg::LRC_NUM-1:0] o_reg_on,
    output logic [lrc_pkg::LRC_NUM-1:0] o_pulldown_on,
    output logic [lrc_pkg::LRC_NUM-1:0] o_voltage_second
);
    import lrc_pkg::*;

    localparam int CNT_W = $clog2(STEP_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam int A_WAIT_MAX = STEP_CYCLES;

    logic [2:0] pins;
    logic [2:0] pins_prev;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [7:0] ctrl [LRC_NUM];
    logic [LRC_NUM-1:0] volt;
    logic [LRC_NUM-1:0] request;
    logic [LRC_NUM-1:0] pdoff;
    logic [LRC_NUM-1:0] pending;
    logic [LRC_NUM-1:0] first_pending;
    logic volt_wr;

    lrc_state_e state;
    lrc_state_e next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [LRC_NUM-1:0] actual;
    logic [LRC_NUM-1:0] next_actual;
    logic [LRC_NUM-1:0] next_pulldown;
    logic [7:0] next_rdata;
    logic next_rd_valid;

    // input edge detection
    assign pins = {i_general_input_three, i_general_input_two,
        i_general_input_one};
    assign rise = pins & ~pins_prev;
    assign fall = ~pins & pins_prev;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pins_prev <= 3'h0;
        end else begin
            pins_prev <= pins;
        end
    end

    assign volt_wr = i_wr_en && (i_addr == LRC_ADDR_VSEL);

    genvar g;
    generate
        for (g = 0; g < LRC_NUM; g++) begin : g_chan
            lrc_channel u_chan (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                .i_ctrl_wr(i_wr_en &&
                    (i_addr == LRC_ADDR_CTRL1 + LRC_ADDR_W'(g))),
                .i_wdata(i_wdata),
                .i_volt_wr(volt_wr),
                .i_volt_wdata(i_wdata[LRC_VSEL_BASE + g]),
                .i_standby(i_low_power_standby_state),
                .i_rise(rise),
                .i_fall(fall),
                .o_ctrl(ctrl[g]),
                .o_volt_second(volt[g]),
                .o_request(request[g])
            );
            assign pdoff[g] = ctrl[g][LRC_BIT_PDOFF];
        end
    endgenerate

    // RULE7: changes wait for a priority step
    assign pending = request ^ actual;
    assign first_pending = pending & (~pending + 4'h1);

    always_comb begin
        next_state = state;
        next_count = count;
        next_actual = actual;
        case (state)
            LRC_ST_IDLE: begin
                next_count = CNT_ZERO;
                if (pending != 4'h0) begin
                    next_state = LRC_ST_WAIT;
                end
            end
            LRC_ST_WAIT: begin
                if (count == CNT_LAST) begin
                    next_state = LRC_ST_APPLY;
                end else begin
                    next_count = count + CNT_W'(1);
                end
            end
            LRC_ST_APPLY: begin
                // lowest numbered regulator switches first
                next_actual = actual ^ first_pending;
                next_state = LRC_ST_IDLE;
            end
            default: begin
                next_state = LRC_ST_IDLE;
                next_count = CNT_ZERO;
            end
        endcase
        // RULE6: pull-down follows off state and bit 3
        next_pulldown = ~next_actual & ~pdoff;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state <= LRC_ST_IDLE;
            count <= CNT_ZERO;
            actual <= 4'h0;
            o_pulldown_on <= 4'hF;
        end else begin
            state <= next_state;
            count <= next_count;
            actual <= next_actual;
            o_pulldown_on <= next_pulldown;
        end
    end

    assign o_reg_on = actual;

    // register read port
    always_comb begin
        next_rd_valid = i_rd_en;
        next_rdata = LRC_RDATA_NONE;
        if (i_rd_en) begin
            case (i_addr)
                LRC_ADDR_CTRL1: next_rdata = ctrl[0];
                LRC_ADDR_CTRL2: next_rdata = ctrl[1];
                LRC_ADDR_CTRL3: next_rdata = ctrl[2];
                LRC_ADDR_CTRL4: next_rdata = ctrl[3];
                LRC_ADDR_VSEL: next_rdata = {volt, 4'h0};
                default: next_rdata = LRC_RDATA_NONE;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_rdata <= LRC_RDATA_NONE;
            o_rd_valid <= 1'b0;
            o_voltage_second <= 4'h0;
        end else begin
            o_rdata <= next_rdata;
            o_rd_valid <= next_rd_valid;
            o_voltage_second <= volt;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_switch_on_step: assert property ( // RULE7
        $changed(o_reg_on) |-> $past(state) == LRC_ST_APPLY)
        else $error("regulator switched outside a step");
    a_single_switch: assert property ( // RULE7
        $changed(o_reg_on) |-> $onehot(o_reg_on ^ $past(o_reg_on)))
        else $error("more than one regulator switched at once");
    a_wait_bounded: assert property ( // RULE7
        $rose(state == LRC_ST_WAIT) |-> ##[1:A_WAIT_MAX]
            state == LRC_ST_APPLY)
        else $error("step wait overran");
    a_pulldown_state: assert property ( // RULE6
        o_pulldown_on == (~o_reg_on & ~$past(pdoff)))
        else $error("pull-down does not follow off state");
    a_read_ctrl: assert property ( // RULE3
        (i_rd_en && i_addr == LRC_ADDR_CTRL2) |=>
            o_rd_valid && o_rdata == $past(ctrl[1]))
        else $error("control register read wrong");
    a_volt_out: assert property ( // RULE8
        (volt_wr && $stable(pins)) |=> ##1
            o_voltage_second == $past(i_wdata[LRC_VSEL_BASE +: LRC_NUM], 2))
        else $error("voltage selection output wrong");
    c_apply_step: cover property (state == LRC_ST_APPLY);
    c_standby_kept: cover property (
        i_low_power_standby_state && o_reg_on[0]);
    c_read_vsel: cover property (i_rd_en && i_addr == LRC_ADDR_VSEL);
endmodule
`default_nettype wire

// [bench/lrc_host.sv]
// host partner: drives register requests and general input pins
// assumes the bank takes requests on the rising edge of i_clock
`timescale 1ns/1ps
`default_nettype none
module lrc_host (
    input wire logic i_clock,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rdata,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [9:0] o_addr,
    output logic [7:0] o_wdata,
    output logic [3:0] o_pins
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 10'h000;
        o_wdata = 8'h00;
        o_pins = 4'h0;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] dat);
        @(posedge i_clock);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= dat;
        @(posedge i_clock);
        o_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] dat,
                      output logic vld);
        @(posedge i_clock);
        o_rd_en <= 1'b1;
        o_addr <= a;
        @(posedge i_clock);
        o_rd_en <= 1'b0;
        #1;
        vld = i_rd_valid;
        dat = i_rdata;
    endtask
    // pin 3 is the standby level, 0..2 the general inputs
    task automatic pin(input int k, input logic val);
        @(posedge i_clock);
        o_pins[k] <= val;
    endtask
endmodule
`default_nettype wire

// [bench/tb_linear_regulator_control_regs.sv]
// bench for the regulator control bank with a behavioural model
// assumes lrc_pkg is compiled first and lrc_host drives the bus
`timescale 1ns/1ps
`default_nettype none
module tb_linear_regulator_control_regs;
    import lrc_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic wr_en, rd_en, rd_valid, v;
    logic [9:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [3:0] pins, reg_on, pd_on, vsec;
    int failures = 0;
    int total_checks = 0;
    int ctrl [4];
    int vbits = 0;
    always #25 i_clock = ~i_clock;
    lrc_regs #(.STEP_CYCLES(2)) u_lrc_regs (
        .i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata),
        .i_general_input_one(pins[0]),
        .i_general_input_two(pins[1]),
        .i_general_input_three(pins[2]),
        .i_low_power_standby_state(pins[3]),
        .o_rdata(rdata), .o_rd_valid(rd_valid), .o_reg_on(reg_on),
        .o_pulldown_on(pd_on), .o_voltage_second(vsec)
    );
    lrc_host u_lrc_host (
        .i_clock(i_clock), .i_rd_valid(rd_valid), .i_rdata(rdata),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
        .o_wdata(wdata), .o_pins(pins)
    );
    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // model of the requested on state
    function automatic logic [3:0] want(input logic sb);
        logic [3:0] r;
        for (int n = 0; n < 4; n++) r[n] = ctrl[n][0] & (!sb | ctrl[n][7]);
        return r;
    endfunction
    task automatic rchk(input int n);
        u_lrc_host.rd(LRC_ADDR_CTRL1 + 10'(n), d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, 8'(ctrl[n]));
    endtask
    task automatic wrc(input int n, input int val);
        ctrl[n] = val;
        u_lrc_host.wr(LRC_ADDR_CTRL1 + 10'(n), 8'(val));
    endtask
    task automatic wait_on(input logic [3:0] exp);
        int i;
        for (i = 0; i < 100; i++) begin
            @(posedge i_clock);
            #1;
            if (reg_on === exp) break;
        end
        if (i == 100) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, reg_on, exp);
            stop_test();
        end
    endtask
    task automatic settle(input logic sb);
        logic [3:0] w, p, cur, dif;
        logic [3:0] steps [$];
        w = want(sb);
        for (int n = 0; n < 4; n++) p[n] = !w[n] && !ctrl[n][3];
        // one regulator per step, lowest numbered first
        cur = reg_on;
        for (int s = 0; s < 4 && cur != w; s++) begin
            dif = cur ^ w;
            cur = cur ^ (dif & (~dif + 4'h1));
            steps.push_back(cur);
        end
        repeat (3) @(posedge i_clock);
        while (steps.size() > 0) wait_on(steps.pop_front());
        wait_on(w);
        chk(8'(reg_on), 8'(w));
        chk(8'(pd_on), 8'(p));
        chk(8'(vsec), 8'(vbits));
    endtask
    // drive a general input and apply its edge to the model
    task automatic toggle_in(input int k, input logic val);
        u_lrc_host.pin(k, val);
        for (int n = 0; n < 4; n++) begin
            if (((ctrl[n] >> 1) & 3) == k + 1) ctrl[n][0] = val;
            if (((ctrl[n] >> 5) & 3) == k + 1) vbits[n] = !val;
        end
    endtask
    initial begin
        void'($urandom(32'h0d14));
        for (int n = 0; n < 4; n++) ctrl[n] = 0;
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int n = 0; n < 4; n++) rchk(n);
        u_lrc_host.rd(LRC_ADDR_VSEL, d, v);
        chk(d, 8'h00);
        settle(1'b0);
        for (int n = 0; n < 4; n++) wrc(n, $urandom & 8'h98);
        for (int n = 0; n < 4; n++) rchk(n);
        settle(1'b0);
        u_lrc_host.rd(10'h030, d, v);
        chk(d, 8'h00);
        vbits = $urandom & 8'h0F;
        u_lrc_host.wr(LRC_ADDR_VSEL, 8'(vbits << 4) | 8'h0F);
        settle(1'b0);
        wrc(0, 8'h09);
        wrc(1, 8'h81);
        chk(8'(reg_on), 8'h00);
        wait_on(4'h1);
        chk(8'(reg_on), 8'h01);
        settle(1'b0);
        u_lrc_host.pin(3, 1'b1);
        settle(1'b1);
        u_lrc_host.pin(3, 1'b0);
        settle(1'b0);
        for (int k = 0; k < 3; k++) begin
            wrc(2, (k + 1) << 1);
            toggle_in(k, 1'b1);
            settle(1'b0);
            rchk(2);
            toggle_in(k, 1'b0);
            settle(1'b0);
        end
        wrc(2, 0);
        for (int k = 0; k < 3; k++) begin
            wrc(3, (k + 1) << 5);
            toggle_in(k, 1'b1);
            settle(1'b0);
            rchk(3);
            toggle_in(k, 1'b0);
            settle(1'b0);
        end
        u_lrc_host.rd(LRC_ADDR_VSEL, d, v);
        chk(d, 8'(vbits << 4));
        // reset in mid-run returns every register to zero
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int n = 0; n < 4; n++) ctrl[n] = 0;
        vbits = 0;
        for (int n = 0; n < 4; n++) rchk(n);
        u_lrc_host.rd(LRC_ADDR_VSEL, d, v);
        chk(d, 8'h00);
        settle(1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
